/* verilog/cca_pkg.sv */
// Package for the carry chain adder slice: constants and carried types
package cca_pkg;
  // ---------------------------------------------------------------
  // Geometry and reset values
  // ---------------------------------------------------------------
  localparam int CELLS_PER_GROUP = 10;
  localparam int DEF_WIDTH = 16;
  localparam int GROUP_PARITY_STEP = 2;
  localparam logic REG_RESET_VAL = 1'h0;

  // Output source select for one of the two cell outputs
  typedef enum logic [1:0] {
    CCA_SRC_LUT = 2'h1,
    CCA_SRC_REG = 2'h2
  } cca_src_e;

  // Per-slice configuration carried as one bundle
  typedef struct packed {
    logic use_reg;
    logic accumulate;
    cca_src_e out_a_src;
    cca_src_e out_b_src;
  } cca_cfg_s;
endpackage

/* verilog/cca_slice.sv */
// Ripple-carry adder slice of n+1 logic cells with optional accumulator registers
`timescale 1ns/1ps

// How it works
// [RL1] Carry in from lower cell feeds lookup logic and the onward carry path.
// [RL2] An n-bit adder uses n+1 cells; the extra one takes the final carry.
// [RL3] Sum bit comes from both operand bits plus the incoming carry.
// [RL4] Register is selectable: bypass gives a plain adder, use gives an accumulator.
// [RL5] Top carry enters the extra cell and leaves as an ordinary output.
// [RL6] Two outputs per cell, each independently from lookup result or register.
// [RL7] A cell may drive registered and unregistered lookup results together; here lut_comb is also a registered copy (comb_reg).
// [RL8] Inside a cell group the carry links positions one to ten in order.
// [RL9] Chains over ten cells jump to the next group of equal parity.
// [RL10] Carry out is the majority of both operands and carry in.
module cca_slice #(
  parameter int WIDTH = cca_pkg::DEF_WIDTH
) (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic srst,
  input wire logic clk_en,
  // Configuration
  input wire cca_pkg::cca_cfg_s cfg,
  // Operands from routing
  input wire logic [WIDTH-1:0] op_a,
  input wire logic [WIDTH-1:0] op_b,
  input wire logic carry_in,
  // Results to routing, two per cell
  output logic [WIDTH:0] out_a,
  output logic [WIDTH:0] out_b,
  // Registered copy of the lookup result and the held register value at once
  output logic [WIDTH:0] lut_comb,
  output logic [WIDTH:0] lut_q,
  // Group index of each cell, for placement checks
  output logic [WIDTH:0][7:0] cell_group
);
  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------
  function automatic logic maj3(input logic x, input logic y, input logic z);
    maj3 = (x & y) | (x & z) | (y & z);
  endfunction

  // Group of a cell: odd/even groups chain by skipping alternate groups
  function automatic logic [7:0] group_of(input int idx);
    int seg;
    seg = idx / cca_pkg::CELLS_PER_GROUP;
    group_of = 8'((seg / 2) * 4 + (seg % 2) * cca_pkg::GROUP_PARITY_STEP);
  endfunction

  // ---------------------------------------------------------------
  // Combinational carry chain and lookup results
  // ---------------------------------------------------------------
  logic [WIDTH:0] carry;
  logic [WIDTH:0] lut_res;
  logic [WIDTH-1:0] a_eff;
  logic [WIDTH:0] q_reg;
  logic [WIDTH:0] q_next;
  logic [WIDTH:0] out_a_next;
  logic [WIDTH:0] out_b_next;
  logic [WIDTH:0] comb_reg;

  // Ripple, one cell after another in fixed order
  always_comb begin
    // Accumulate feeds the held sum back as operand a
    a_eff = cfg.accumulate ? q_reg[WIDTH-1:0] : op_a;
    carry[0] = carry_in;
    for (int i = 0; i < WIDTH; i++) begin
      lut_res[i] = a_eff[i] ^ op_b[i] ^ carry[i]; // see RL3, see RL1
      carry[i+1] = maj3(a_eff[i], op_b[i], carry[i]); // see RL10, see RL8, see RL1
    end
    // Extra cell passes the final carry onto routing
    lut_res[WIDTH] = carry[WIDTH]; // see RL2, see RL5
  end

  // Register stage and output steering
  always_comb begin
    q_next = q_reg;
    if (clk_en && cfg.use_reg) begin
      q_next = lut_res; // see RL4
    end
    for (int i = 0; i <= WIDTH; i++) begin
      // Register source shows the held value only when the register is in use
      out_a_next[i] = (cfg.out_a_src == cca_pkg::CCA_SRC_REG && cfg.use_reg) ?
                      q_next[i] : lut_res[i]; // see RL6
      out_b_next[i] = (cfg.out_b_src == cca_pkg::CCA_SRC_REG && cfg.use_reg) ?
                      q_next[i] : lut_res[i]; // see RL6
    end
  end

  // All outputs registered; outputs lag the lookup by one cycle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      q_reg <= {(WIDTH+1){cca_pkg::REG_RESET_VAL}};
      out_a <= '0;
      out_b <= '0;
      comb_reg <= '0;
    end else if (clk_en) begin
      q_reg <= q_next;
      out_a <= out_a_next;
      out_b <= out_b_next;
      comb_reg <= lut_res;
    end
  end

  // Registered lookup copy and held register value side by side
  always_comb begin
    lut_comb = comb_reg; // see RL7
    lut_q = q_reg; // see RL7
  end

  // Placement map is a constant; reset loads it so it is never unknown
  logic [WIDTH:0][7:0] cell_group_next;

  always_comb begin
    for (int i = 0; i <= WIDTH; i++) begin
      cell_group_next[i] = group_of(i); // see RL9
    end
  end

  // Frozen by the enable like all other state
  always_ff @(posedge core_clk) begin
    if (srst || clk_en) begin
      cell_group <= cell_group_next; // see RL8
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_sum_bit0: assert property (@(posedge core_clk) disable iff (srst) // see RL3
    clk_en |=> lut_comb[0] == $past(a_eff[0] ^ op_b[0] ^ carry_in))
    else $error("sum bit 0 wrong");
  a_carry_maj: assert property (@(posedge core_clk) disable iff (srst) // see RL10
    carry[1] == ((a_eff[0] & op_b[0]) | (carry_in & (a_eff[0] ^ op_b[0]))))
    else $error("carry majority wrong");
  a_top_carry: assert property (@(posedge core_clk) disable iff (srst) // see RL5
    clk_en |=> lut_comb[WIDTH] ==
      $past(({1'b0, a_eff} + {1'b0, op_b} + (WIDTH+1)'(carry_in)) >> WIDTH))
    else $error("final carry cell wrong");
  a_reg_hold: assert property (@(posedge core_clk) disable iff (srst) // see RL4
    !cfg.use_reg |=> $stable(q_reg) || !$past(clk_en) || $past(cfg.use_reg))
    else $error("register changed while bypassed");
  a_reg_capture: assert property (@(posedge core_clk) disable iff (srst) // see RL4
    (clk_en && cfg.use_reg) |=> q_reg == $past(lut_res))
    else $error("register did not capture sum");
  a_out_lut: assert property (@(posedge core_clk) disable iff (srst) // see RL6
    (clk_en && cfg.out_a_src == cca_pkg::CCA_SRC_LUT) |=> out_a == $past(lut_res))
    else $error("output a not lookup");
  a_both_forms: assert property (@(posedge core_clk) disable iff (srst) // see RL7
    (clk_en && cfg.use_reg) |=> lut_comb == lut_q)
    else $error("forms disagree");
  a_chain_sum: assert property (@(posedge core_clk) disable iff (srst) // see RL1
    lut_res == ({1'b0, a_eff} + {1'b0, op_b} + (WIDTH+1)'(carry_in)))
    else $error("ripple sum wrong");
  a_group_skip: assert property (@(posedge core_clk) disable iff (srst) // see RL9
    ##1 (WIDTH < cca_pkg::CELLS_PER_GROUP ||
         cell_group[cca_pkg::CELLS_PER_GROUP] == 8'(cca_pkg::GROUP_PARITY_STEP)))
    else $error("group skip wrong");
  a_in_group: assert property (@(posedge core_clk) disable iff (srst) // see RL8
    ##1 cell_group[0] == cell_group[cca_pkg::CELLS_PER_GROUP-1] ||
        WIDTH < cca_pkg::CELLS_PER_GROUP)
    else $error("group order wrong");


  // ---------------------------------------------------------------
  // Per-bit arithmetic checks
  // ---------------------------------------------------------------
  a_sum_top: assert property (@(posedge core_clk) disable iff (srst) // see RL3
    clk_en |=> lut_comb[WIDTH-1] == $past(a_eff[WIDTH-1] ^ op_b[WIDTH-1] ^ carry[WIDTH-1]))
    else $error("top sum bit wrong");
  a_carry_top: assert property (@(posedge core_clk) disable iff (srst) // see RL10
    carry[WIDTH] == ((a_eff[WIDTH-1] & op_b[WIDTH-1]) | (a_eff[WIDTH-1] & carry[WIDTH-1]) |
                     (op_b[WIDTH-1] & carry[WIDTH-1])))
    else $error("top carry majority wrong");
  a_top_out_a: assert property (@(posedge core_clk) disable iff (srst) // see RL5
    clk_en |=> out_a[WIDTH] == $past(carry[WIDTH]))
    else $error("final carry missing on output a");
  a_top_out_b: assert property (@(posedge core_clk) disable iff (srst) // see RL5
    clk_en |=> out_b[WIDTH] == $past(carry[WIDTH]))
    else $error("final carry missing on output b");

  // ---------------------------------------------------------------
  // Register, output and freeze checks
  // ---------------------------------------------------------------
  a_out_b_lut: assert property (@(posedge core_clk) disable iff (srst) // see RL6
    (clk_en && cfg.out_b_src == cca_pkg::CCA_SRC_LUT) |=> out_b == $past(lut_res))
    else $error("output b not lookup");
  a_out_a_reg: assert property (@(posedge core_clk) disable iff (srst) // see RL6
    (clk_en && cfg.use_reg && cfg.out_a_src == cca_pkg::CCA_SRC_REG) |=> out_a == lut_q)
    else $error("output a not register");
  a_out_b_reg: assert property (@(posedge core_clk) disable iff (srst) // see RL6
    (clk_en && cfg.use_reg && cfg.out_b_src == cca_pkg::CCA_SRC_REG) |=> out_b == lut_q)
    else $error("output b not register");
  a_bypass_hold: assert property (@(posedge core_clk) disable iff (srst) // see RL4
    (clk_en && !cfg.use_reg) |=> $stable(q_reg))
    else $error("bypassed register captured");
  a_accum_feed: assert property (@(posedge core_clk) disable iff (srst) // see RL4
    (clk_en && cfg.use_reg && cfg.accumulate) |=>
      lut_q == $past({1'b0, q_reg[WIDTH-1:0]} + {1'b0, op_b} + (WIDTH+1)'(carry_in)))
    else $error("accumulator step wrong");
  a_freeze_out: assert property (@(posedge core_clk) disable iff (srst) // see RL6
    !clk_en |=> $stable(out_a) && $stable(out_b) && $stable(lut_comb))
    else $error("outputs moved while disabled");
  a_freeze_state: assert property (@(posedge core_clk) disable iff (srst) // see RL4
    !clk_en |=> $stable(q_reg) && $stable(cell_group))
    else $error("state moved while disabled");

  // ---------------------------------------------------------------
  // Reset and placement checks
  // ---------------------------------------------------------------
  a_reset_clear: assert property (@(posedge core_clk) // see RL4
    $fell(srst) |-> (out_a == '0 && out_b == '0 && lut_comb == '0 && lut_q == '0))
    else $error("results not cleared by reset");
  a_group_fixed: assert property (@(posedge core_clk) disable iff (srst) // see RL8
    ##1 $stable(cell_group))
    else $error("placement map changed");

  // ---------------------------------------------------------------
  // Coverage of the main scenarios
  // ---------------------------------------------------------------
  c_accum: cover property (@(posedge core_clk) cfg.accumulate && cfg.use_reg && clk_en);
  c_overflow: cover property (@(posedge core_clk) carry[WIDTH] && clk_en);
  c_packed: cover property (@(posedge core_clk) cfg.out_a_src != cfg.out_b_src);
  c_bypass: cover property (@(posedge core_clk) clk_en && !cfg.use_reg && !srst);
  c_freeze: cover property (@(posedge core_clk) !clk_en && !srst);
endmodule

/* dv/cca_route_model.sv */
// Routing fabric model that carries operand b and the chain carry into the slice
`timescale 1ns/1ps

module cca_route_model #(
  parameter int WIDTH = 12
) (
  // From neighbouring logic
  input wire logic [WIDTH-1:0] src_b,
  input wire logic src_c,
  // Into the slice
  output logic [WIDTH-1:0] op_b,
  output logic carry_in
);
  // Plain wires: routing adds no state, so timing stays the bench's
  assign op_b = src_b;
  assign carry_in = src_c;
endmodule

/* dv/cca_slice_tb.sv */
// Self-checking bench for the carry chain adder slice
`timescale 1ns/1ps

module cca_slice_tb;
  localparam int W = 12;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic clk_en = 1'b0;
  cca_pkg::cca_cfg_s cfg = '0;
  logic [W-1:0] op_a = '0;
  logic [W-1:0] rb = '0;
  logic rc = 1'b0;
  logic [W-1:0] op_b;
  logic carry_in;
  logic [W:0] out_a, out_b, lut_comb, lut_q;
  logic [W:0][7:0] cell_group;
  logic [W:0] m_s = '0;
  logic [W:0] m_q = '0;
  logic [31:0] rs = 32'h5d;
  int mismatches = 0;
  int compares = 0;

  cca_route_model #(.WIDTH(W)) cca_route_model_inst (.src_b(rb), .src_c(rc), .op_b(op_b),
    .carry_in(carry_in));
  cca_slice #(.WIDTH(W)) cca_slice_inst (.core_clk(core_clk), .srst(srst), .clk_en(clk_en),
    .cfg(cfg), .op_a(op_a), .op_b(op_b), .carry_in(carry_in), .out_a(out_a), .out_b(out_b),
    .lut_comb(lut_comb), .lut_q(lut_q), .cell_group(cell_group));

  // Clock, 5 ns period
  always #2.5 core_clk = ~core_clk;

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  task automatic chk(input string n, input logic [W:0] e, input logic [W:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  // Drive one cycle and advance the integer model when enabled
  task automatic drive(input logic en, input logic ur, input logic acc, input logic [31:0] r);
    clk_en = en;
    cfg.use_reg = ur;
    cfg.accumulate = acc & ur;
    cfg.out_a_src = r[4] ? cca_pkg::CCA_SRC_LUT : cca_pkg::CCA_SRC_REG;
    cfg.out_b_src = r[5] ? cca_pkg::CCA_SRC_LUT : cca_pkg::CCA_SRC_REG;
    op_a = r[17:6];
    rb = r[29:18];
    rc = r[30];
    if (en) begin
      // Held sum replaces operand a in accumulator mode
      m_s = (W+1)'(cfg.accumulate ? m_q[W-1:0] : op_a) + (W+1)'(rb) + (W+1)'(rc);
      if (ur) m_q = m_s;
    end
  endtask

  // Check the previous cycle's result, then apply fresh random inputs
  task automatic step();
    @(posedge core_clk);
    #1;
    chk("out_a", m_s, out_a);
    chk("out_b", m_s, out_b);
    chk("lut_comb", m_s, lut_comb);
    chk("lut_q", m_q, lut_q);
    rs = xs(rs);
    drive(rs[0] | rs[1], rs[2], rs[3], rs);
  endtask

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Watchdog well beyond the expected 1.5 us run
  initial begin
    #20000;
    mismatches++;
    end_of_test();
  end

  initial begin
    repeat (8) @(posedge core_clk);
    #1;
    srst = 1'b0;
    drive(1'b1, 1'b1, 1'b0, {1'b0, 12'h005, 12'h003, 6'h10});
    for (int i = 0; i <= W; i++) begin
      chk("cell_group", (W+1)'(i < 10 ? 0 : 2), (W+1)'(cell_group[i]));
    end
    repeat (150) step();
    // Mid-run reset with the enable low, so nothing moves after release
    srst = 1'b1;
    clk_en = 1'b0;
    @(posedge core_clk);
    #1;
    srst = 1'b0;
    m_s = '0;
    m_q = '0;
    chk("rst_out_a", '0, out_a);
    chk("rst_lut_q", '0, lut_q);
    repeat (150) step();
    end_of_test();
  end
endmodule
